// [hdl/swrl_pkg.sv]
// Shared constants and encodings for the single-wire slave ROM layer
package swrl_pkg;

  // System clock period
  localparam int unsigned CLK_NS          = 4;

  // ROM-level command codes
  localparam logic [7:0]  CMD_READ_ROM    = 8'h33;
  localparam logic [7:0]  CMD_MATCH       = 8'h55;
  localparam logic [7:0]  CMD_SEARCH      = 8'hF0;
  localparam logic [7:0]  CMD_SKIP        = 8'hCC;
  localparam logic [7:0]  CMD_RESUME      = 8'hA5;
  localparam logic [7:0]  CMD_OD_SKIP     = 8'h3C;
  localparam logic [7:0]  CMD_OD_MATCH    = 8'h69;

  // Frame sizes
  localparam int unsigned CMD_BITS        = 8;
  localparam int unsigned ROM_BITS        = 64;

  // Reset low thresholds in microseconds
  localparam int unsigned RST_LONG_US     = 480;
  localparam int unsigned OD_KEEP_MAX_US  = 80;
  localparam int unsigned OD_RST_MIN_US   = 48;

  // Presence timing at standard speed in microseconds
  localparam int unsigned STD_PDH_US      = 30;
  localparam int unsigned STD_PDL_US      = 120;

  // Short timings in nanoseconds
  localparam int unsigned OD_PDH_NS       = 2000;
  localparam int unsigned OD_PDL_NS       = 8000;
  localparam int unsigned STD_SAMPLE_NS   = 15000;
  localparam int unsigned OD_SAMPLE_NS    = 2000;
  localparam int unsigned STD_HOLD_NS     = 12000;
  localparam int unsigned OD_HOLD_NS      = 1500;
  localparam int unsigned STD_REC_NS      = 5000;
  localparam int unsigned OD_REC_NS       = 2000;

  // Derived cycle counts: least times round up, longest round down
  localparam int unsigned OD_PDH_CYC      = (OD_PDH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OD_PDL_CYC      = (OD_PDL_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned STD_SAMPLE_CYC  = (STD_SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OD_SAMPLE_CYC   = (OD_SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned STD_HOLD_CYC    = STD_HOLD_NS / CLK_NS;
  localparam int unsigned OD_HOLD_CYC     = OD_HOLD_NS / CLK_NS;
  localparam int unsigned STD_REC_CYC     = (STD_REC_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OD_REC_CYC      = (OD_REC_NS + CLK_NS - 1) / CLK_NS;

  // Reset values
  localparam logic        OD_RST_VAL      = 1'b0;
  localparam logic        RC_RST_VAL      = 1'b0;

  // Line-level phase of the slot engine
  typedef enum logic [2:0] {
    swrl_ln_idle,
    swrl_ln_pres_wait,
    swrl_ln_pres_low,
    swrl_ln_slot,
    swrl_ln_rec
  } swrl_line_t;

  // ROM-layer state
  typedef enum logic [2:0] {
    swrl_rom_cmd,
    swrl_rom_read_id,
    swrl_rom_match,
    swrl_rom_search,
    swrl_rom_mem,
    swrl_rom_wait_rst
  } swrl_rom_t;

endpackage : swrl_pkg

// [hdl/swrl_rom_layer.sv]
// Single-wire slave: reset/presence, bit slots, speed state and ROM commands
//
// Summary of operation
// - Search code walks ID bits LSB first
// - Search slots drive true bit, then complement
// - Third slot mismatch drops device until reset
// - Skip code goes straight to memory layer
// - Resume selects only when resume flag set
// - Resume flag set by match/search/overdrive-match success
// - Other device selected clears resume flag
// - Overdrive-skip sets overdrive and skips addressing
// - Reset low of 480 us clears overdrive
// - Overdrive-match: exact match selects and sets overdrive
// - Failed overdrive-match keeps existing overdrive
// - Overdrive reset up to 80 us keeps overdrive
// - Standard timing unless overdrive or overdrive-match ID bits; overdrive times all
// - Presence: wait delay, then drive low period
// - Data slots accepted after presence and recovery
// - Falling edge starts slot timer for sampling
// - Recovery interval after each slot rise
// - Read zero pulls low for timed hold
// - ROM commands are eight bits, LSB first
// - Match code: exact 64-bit match selects
// - Read-ID code sends 64-bit registration number
`timescale 1ns/1ns

module swrl_rom_layer
  import swrl_pkg::*;
#(
  parameter logic [63:0] ROM_ID       = 64'h0123_4567_89AB_CD01, // Arbitrary value
  parameter int unsigned DW           = 8,
  parameter int unsigned DEPTH        = 2,
  parameter int unsigned RST_LONG_CYC = RST_LONG_US * 1000 / CLK_NS,
  parameter int unsigned OD_KEEP_CYC  = OD_KEEP_MAX_US * 1000 / CLK_NS,
  parameter int unsigned OD_RST_CYC   = OD_RST_MIN_US * 1000 / CLK_NS,
  parameter int unsigned STD_PDH_CYC  = (STD_PDH_US * 1000 + CLK_NS - 1) / CLK_NS,
  parameter int unsigned STD_PDL_CYC  = (STD_PDL_US * 1000 + CLK_NS - 1) / CLK_NS
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_sys_rst,
  input  wire logic          i_dq,
  output logic               o_dq_out,
  output logic               o_dq_oe,
  output logic               o_overdrive_flag,
  output logic               o_resume_flag,
  output logic               o_selected,
  output logic               o_reset_seen,
  output logic [DW-1:0]      o_mem_data,
  output logic               o_mem_valid,
  input  wire logic          i_mem_ready
);

  localparam int unsigned LW = 17;  // Wide enough for the 480 us low count
  localparam int unsigned TW = 17;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic                       dq_s1;
    logic                       dq_s2;
    logic                       dq_prev;
    logic [LW-1:0]              low_cnt;
    logic [TW-1:0]              tmr;
    swrl_line_t                 line;
    swrl_rom_t                  rom;
    logic                       od;
    logic                       rc;
    logic                       odm;
    logic                       match_ok;
    logic                       rd_slot;
    logic                       rd_bit;
    logic                       done;
    logic [6:0]                 bit_cnt;
    logic [1:0]                 sub;
    logic [7:0]                 shreg;
    logic                       drv;
    logic                       dq_o;
    logic                       rst_seen;
    logic                       rst_od;
    logic                       sel;
    logic                       mvalid;
    logic                       pend_v;
    logic [DW-1:0]              pend_d;
    logic [DEPTH-1:0][DW-1:0]   buf_d;
    logic [CW-1:0]              buf_cnt;
  } swrl_state_t;

  swrl_state_t st_r;
  swrl_state_t st_nxt;

  // Timing chosen by the current speed, widened for the counters
  function automatic logic [TW-1:0] swrl_pick(input logic od, input int unsigned t_od,
                                               input int unsigned t_std);
    swrl_pick = od ? TW'(t_od) : TW'(t_std);
  endfunction : swrl_pick

  // ROM bit the device would present at a given index
  function automatic logic swrl_id_bit(input logic [6:0] idx);
    swrl_id_bit = ROM_ID[idx[5:0]];
  endfunction : swrl_id_bit

  logic          fall;
  logic          rise;
  logic          od_eff;
  logic          bit_in;
  logic [7:0]    byte_in;
  logic [CW-1:0] cnt_tmp;
  logic          pop;

  // Next-state logic for line, ROM layer and hand-over buffer
  always_comb begin
    st_nxt   = st_r;
    cnt_tmp  = st_r.buf_cnt;
    pop      = 1'b0;
    bit_in   = 1'b0;
    byte_in  = 8'h00;
    st_nxt.dq_s1    = i_dq;
    st_nxt.dq_s2    = st_r.dq_s1;
    st_nxt.dq_prev  = st_r.dq_s2;
    st_nxt.rst_seen = 1'b0;
    st_nxt.dq_o     = 1'b0;
    fall   = st_r.dq_prev & ~st_r.dq_s2;
    rise   = ~st_r.dq_prev & st_r.dq_s2;
    // Overdrive-match bits already travel at fast timing
    od_eff = st_r.od | st_r.odm;

    // Speed at the start of each low decides how a reset is measured,
    // so the slot that sets overdrive is not mistaken for a reset
    if (fall) begin
      st_nxt.rst_od = st_r.od;
    end

    // Low-time measure; our own pulldown is not counted
    if (st_r.dq_s2 || st_r.drv) begin
      st_nxt.low_cnt = '0;
    end else if (st_r.low_cnt != {LW{1'b1}}) begin
      st_nxt.low_cnt = st_r.low_cnt + LW'(1);
    end

    st_nxt.tmr = st_r.tmr + TW'(1);

    case (st_r.line)
      swrl_ln_idle: begin
        if (fall) begin
          st_nxt.tmr  = '0;
          st_nxt.line = swrl_ln_slot;
          st_nxt.done = 1'b0;
          // Read slots: search pair and ID readout
          st_nxt.rd_slot = (st_r.rom == swrl_rom_read_id) ||
                           (st_r.rom == swrl_rom_search && st_r.sub != 2'd2);
          if (st_r.rom == swrl_rom_search) begin
            st_nxt.rd_bit = (st_r.sub == 2'd0) ? swrl_id_bit(st_r.bit_cnt)
                                               : ~swrl_id_bit(st_r.bit_cnt);
          end else begin
            st_nxt.rd_bit = swrl_id_bit(st_r.bit_cnt);
          end
        end
      end
      swrl_ln_pres_wait: begin
        if (st_r.tmr >= swrl_pick(st_r.od, OD_PDH_CYC, STD_PDH_CYC) - TW'(1)) begin
          st_nxt.tmr  = '0;
          st_nxt.line = swrl_ln_pres_low;
        end
      end
      swrl_ln_pres_low: begin
        if (st_r.tmr >= swrl_pick(st_r.od, OD_PDL_CYC, STD_PDL_CYC) - TW'(1)) begin
          st_nxt.tmr  = '0;
          st_nxt.line = swrl_ln_rec;
        end
      end
      swrl_ln_slot: begin
        if (!st_r.done && st_r.tmr == swrl_pick(od_eff, OD_SAMPLE_CYC, STD_SAMPLE_CYC)) begin
          st_nxt.done = 1'b1;
          bit_in = st_r.rd_slot ? st_r.rd_bit : st_r.dq_s2;
          // Bit handling by ROM state
          case (st_r.rom)
            swrl_rom_cmd: begin
              byte_in        = {bit_in, st_r.shreg[7:1]};
              st_nxt.shreg   = byte_in;
              st_nxt.bit_cnt = st_r.bit_cnt + 7'd1;
              if (st_r.bit_cnt == 7'(CMD_BITS - 1)) begin
                st_nxt.bit_cnt  = '0;
                st_nxt.sub      = '0;
                st_nxt.match_ok = 1'b1;
                if (byte_in == CMD_READ_ROM) begin
                  st_nxt.rom = swrl_rom_read_id;
                end else if (byte_in == CMD_MATCH) begin
                  st_nxt.rom = swrl_rom_match;
                end else if (byte_in == CMD_OD_MATCH) begin
                  st_nxt.rom = swrl_rom_match;
                  st_nxt.odm = 1'b1;
                end else if (byte_in == CMD_SEARCH) begin
                  st_nxt.rom = swrl_rom_search;
                end else if (byte_in == CMD_SKIP) begin
                  st_nxt.rom = swrl_rom_mem;
                end else if (byte_in == CMD_OD_SKIP) begin
                  st_nxt.rom = swrl_rom_mem;
                  st_nxt.od  = 1'b1;
                end else if (byte_in == CMD_RESUME) begin
                  st_nxt.rom = st_r.rc ? swrl_rom_mem : swrl_rom_wait_rst;
                end else begin
                  st_nxt.rom = swrl_rom_wait_rst;
                end
              end
            end
            swrl_rom_read_id: begin
              st_nxt.bit_cnt = st_r.bit_cnt + 7'd1;
              if (st_r.bit_cnt == 7'(ROM_BITS - 1)) begin
                st_nxt.rom = swrl_rom_mem;
              end
            end
            swrl_rom_match: begin
              st_nxt.bit_cnt = st_r.bit_cnt + 7'd1;
              if (bit_in != swrl_id_bit(st_r.bit_cnt)) begin
                st_nxt.match_ok = 1'b0;
              end
              if (st_r.bit_cnt == 7'(ROM_BITS - 1)) begin
                st_nxt.odm = 1'b0;
                if (st_nxt.match_ok) begin
                  st_nxt.rom = swrl_rom_mem;
                  st_nxt.rc  = 1'b1;
                  st_nxt.od  = st_r.od | st_r.odm;
                end else begin
                  // Someone else was addressed; old overdrive stays
                  st_nxt.rom = swrl_rom_wait_rst;
                  st_nxt.rc  = 1'b0;
                end
              end
            end
            swrl_rom_search: begin
              if (st_r.sub != 2'd2) begin
                st_nxt.sub = st_r.sub + 2'd1;
              end else begin
                st_nxt.sub = '0;
                if (bit_in != swrl_id_bit(st_r.bit_cnt)) begin
                  st_nxt.rom = swrl_rom_wait_rst;
                  st_nxt.rc  = 1'b0;
                end else if (st_r.bit_cnt == 7'(ROM_BITS - 1)) begin
                  st_nxt.rom = swrl_rom_mem;
                  st_nxt.rc  = 1'b1;
                end else begin
                  st_nxt.bit_cnt = st_r.bit_cnt + 7'd1;
                end
              end
            end
            swrl_rom_mem: begin
              // Assemble memory-layer bytes; stalls while one is pending
              if (!st_r.pend_v) begin
                byte_in        = {bit_in, st_r.shreg[7:1]};
                st_nxt.shreg   = byte_in;
                st_nxt.bit_cnt = st_r.bit_cnt + 7'd1;
                if (st_r.bit_cnt == 7'(CMD_BITS - 1)) begin
                  st_nxt.bit_cnt = '0;
                  st_nxt.pend_v  = 1'b1;
                  st_nxt.pend_d  = DW'(byte_in);
                end
              end
            end
            default: begin
              st_nxt.rom = swrl_rom_wait_rst;
            end
          endcase
        end
        if (st_r.done && st_r.dq_s2) begin
          st_nxt.tmr  = '0;
          st_nxt.line = swrl_ln_rec;
        end
      end
      swrl_ln_rec: begin
        // Falling edges inside recovery are not taken as slots
        if (st_r.tmr >= swrl_pick(od_eff, OD_REC_CYC, STD_REC_CYC) - TW'(1)) begin
          st_nxt.line = swrl_ln_idle;
        end
      end
      default: begin
        st_nxt.line = swrl_ln_idle;
      end
    endcase

    // Reset pulse recognised on the release edge, overriding all else
    if (rise && st_r.low_cnt >= (st_r.rst_od ? LW'(OD_RST_CYC) : LW'(RST_LONG_CYC))) begin
      st_nxt.rst_seen = 1'b1;
      st_nxt.line     = swrl_ln_pres_wait;
      st_nxt.tmr      = '0;
      st_nxt.rom      = swrl_rom_cmd;
      st_nxt.bit_cnt  = '0;
      st_nxt.sub      = '0;
      st_nxt.odm      = 1'b0;
      st_nxt.match_ok = 1'b0;
      st_nxt.pend_v   = 1'b0;
      // Up to 80 us keeps overdrive; longer ones fall back to standard
      st_nxt.od = st_r.od && (st_r.low_cnt <= LW'(OD_KEEP_CYC));
    end

    // Pulldown: presence low and read-zero hold only
    st_nxt.drv = (st_nxt.line == swrl_ln_pres_low) ||
                 (st_nxt.line == swrl_ln_slot && st_nxt.rd_slot && !st_nxt.rd_bit &&
                  st_nxt.tmr < swrl_pick(od_eff, OD_HOLD_CYC, STD_HOLD_CYC));

    // Two-entry buffer, head in entry 0 so the output is a flop
    if (st_r.buf_cnt != '0 && i_mem_ready) begin
      pop = 1'b1;
      for (int i = 0; i < DEPTH - 1; i++) begin
        st_nxt.buf_d[i] = st_r.buf_d[i + 1];
      end
      cnt_tmp = st_r.buf_cnt - CW'(1);
    end
    if (st_r.pend_v && (st_r.buf_cnt != CW'(DEPTH) || pop)) begin
      st_nxt.buf_d[cnt_tmp] = st_r.pend_d;
      cnt_tmp = cnt_tmp + CW'(1);
      if (!st_nxt.rst_seen) begin
        st_nxt.pend_v = 1'b0;
      end
    end
    st_nxt.buf_cnt = cnt_tmp;
    // Registered copies so the status outputs come from flops
    st_nxt.mvalid  = (cnt_tmp != '0);
    st_nxt.sel     = (st_nxt.rom == swrl_rom_mem);
  end

  // State register
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r         <= '0;
      st_r.dq_s1   <= 1'b1;
      st_r.dq_s2   <= 1'b1;
      st_r.dq_prev <= 1'b1;
      st_r.line    <= swrl_ln_idle;
      st_r.rom     <= swrl_rom_wait_rst;
      st_r.od      <= OD_RST_VAL;
      st_r.rc      <= RC_RST_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops
  assign o_dq_out         = st_r.dq_o;
  assign o_dq_oe          = st_r.drv;
  assign o_overdrive_flag = st_r.od;
  assign o_resume_flag    = st_r.rc;
  assign o_selected       = st_r.sel;
  assign o_reset_seen     = st_r.rst_seen;
  assign o_mem_data       = st_r.buf_d[0];
  assign o_mem_valid      = st_r.mvalid;

endmodule : swrl_rom_layer

// [verification/swrl_rom_layer_monitor.sv]
// Port checker for the single-wire slave ROM layer
`timescale 1ns/1ns

module swrl_rom_layer_monitor
  import swrl_pkg::*;
#(
  parameter int unsigned DW          = 8,
  parameter int unsigned STD_PDH_CYC = 7500,
  parameter int unsigned STD_PDL_CYC = 30000
) (
  input wire logic          i_clk_sys,
  input wire logic          i_sys_rst,
  input wire logic          i_dq,
  input wire logic          o_dq_out,
  input wire logic          o_dq_oe,
  input wire logic          o_overdrive_flag,
  input wire logic          o_resume_flag,
  input wire logic          o_selected,
  input wire logic          o_reset_seen,
  input wire logic [DW-1:0] o_mem_data,
  input wire logic          o_mem_valid,
  input wire logic          i_mem_ready
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  logic        pres_arm_r;
  logic [15:0] pdh_cnt_r;
  logic [15:0] pdl_cnt_r;
  logic [15:0] pdh_exp;
  logic [15:0] pdl_exp;

  // Expected presence figures follow the speed now in force
  assign pdh_exp = o_overdrive_flag ? 16'(OD_PDH_CYC) : 16'(STD_PDH_CYC);
  assign pdl_exp = o_overdrive_flag ? 16'(OD_PDL_CYC) : 16'(STD_PDL_CYC);

  // Presence tracker: delay counted before the pull, length while pulling
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pres_arm_r <= 1'b0;
      pdh_cnt_r  <= 16'h0000;
      pdl_cnt_r  <= 16'h0000;
    end else if (o_reset_seen) begin
      pres_arm_r <= 1'b1;
      pdh_cnt_r  <= 16'h0000;
      pdl_cnt_r  <= 16'h0000;
    end else if (pres_arm_r) begin
      if (o_dq_oe) begin
        pdl_cnt_r <= pdl_cnt_r + 16'h0001;
      end else if (pdl_cnt_r != 16'h0000) begin
        pres_arm_r <= 1'b0;
      end else begin
        pdh_cnt_r <= pdh_cnt_r + 16'h0001;
      end
    end
  end

  a_seen_pulse: assert property (o_reset_seen |=> !o_reset_seen)
    else $error("reset indication longer than one cycle");
  a_seen_desel: assert property (o_reset_seen |=> !o_selected [*8])
    else $error("selection survived a bus reset");
  a_pres_early: assert property (pres_arm_r && $rose(o_dq_oe) |-> pdh_cnt_r + 16'h0002 >= pdh_exp)
    else $error("presence pull started too early");
  a_pres_late: assert property (pres_arm_r && pdl_cnt_r == 16'h0000 |-> pdh_cnt_r <= pdh_exp + 16'h0002)
    else $error("presence pull started too late");
  a_pres_len: assert property (pres_arm_r && $fell(o_dq_oe)
      |-> pdl_cnt_r + 16'h0002 >= pdl_exp && pdl_cnt_r <= pdl_exp + 16'h0002)
    else $error("presence pull length wrong");
  a_od_set_sel: assert property ($rose(o_overdrive_flag) |-> ##[0:1] o_selected)
    else $error("overdrive set without selection");
  a_od_clear_rst: assert property ($fell(o_overdrive_flag) |-> o_reset_seen || $past(o_reset_seen))
    else $error("overdrive cleared outside a bus reset");
  a_rc_set_sel: assert property ($rose(o_resume_flag) |-> ##[0:1] o_selected)
    else $error("resume flag set without selection");
  a_sel_quiet: assert property (o_selected |-> !o_dq_oe)
    else $error("line pulled while memory layer owns it");
  a_mem_hold: assert property (o_mem_valid && !i_mem_ready |=> o_mem_valid && $stable(o_mem_data))
    else $error("stalled byte lost or changed");
endmodule : swrl_rom_layer_monitor

bind swrl_rom_layer swrl_rom_layer_monitor #(
  .DW(DW), .STD_PDH_CYC(STD_PDH_CYC), .STD_PDL_CYC(STD_PDL_CYC)
) u_swrl_rom_layer_monitor (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_dq(i_dq), .o_dq_out(o_dq_out),
  .o_dq_oe(o_dq_oe), .o_overdrive_flag(o_overdrive_flag), .o_resume_flag(o_resume_flag),
  .o_selected(o_selected), .o_reset_seen(o_reset_seen), .o_mem_data(o_mem_data),
  .o_mem_valid(o_mem_valid), .i_mem_ready(i_mem_ready)
);

// [verification/swrl_master_model.sv]
// Bus master model pulling the open-drain single-wire line
`timescale 1ns/1ns

module swrl_master_model
  import swrl_pkg::*;
#(
  parameter int unsigned STD_PDH = 50,  // Bench's shortened presence figures
  parameter int unsigned STD_PDL = 100
) (
  input  wire logic i_clk_sys,
  input  wire logic i_line,
  output logic      o_pull
);
  // Slot totals leave margin past sample point plus recovery
  localparam int unsigned STD_SLOT = 5020;
  localparam int unsigned OD_SLOT  = 1020;

  initial o_pull = 1'b0;

  task automatic idle(input int unsigned n);
    repeat (n) @(negedge i_clk_sys);
  endtask : idle

  // Reset low then presence sample mid-pulse; speed chosen by caller
  task automatic bus_reset(input int unsigned low, input logic od, output logic pres);
    o_pull = 1'b1;
    idle(low);
    o_pull = 1'b0;
    idle(od ? (3 + OD_PDH_CYC + OD_PDL_CYC / 2) : (3 + STD_PDH + STD_PDL / 2));
    pres = ~i_line;
    idle(od ? (OD_PDL_CYC / 2 + OD_REC_CYC + 100) : (STD_PDL / 2 + STD_REC_CYC + 100));
  endtask : bus_reset

  // Short low for one, low past the sample point for zero
  task automatic write_bit(input logic b, input logic od);
    int unsigned low;
    low = b ? 2 : (od ? OD_SAMPLE_CYC : STD_SAMPLE_CYC) + 8;
    o_pull = 1'b1;
    idle(low);
    o_pull = 1'b0;
    idle((od ? OD_SLOT : STD_SLOT) - low);
  endtask : write_bit

  // Byte least significant bit first; gap lets the master run slow
  task automatic write_byte(input logic [7:0] v, input logic od, input int unsigned gap);
    for (int i = 0; i < 8; i++) begin
      write_bit(v[i], od);
    end
    idle(gap);
  endtask : write_byte
endmodule : swrl_master_model

// [verification/testbench.sv]
// Self-checking bench for the slave ROM layer against the master model
`timescale 1ns/1ns

`define CHK(NM, EXP, ACT) begin samples_checked++; if ((ACT) !== (EXP)) begin err_count++; \
  $display("mismatch %s expected %0h seen %0h", NM, EXP, ACT); end end

module testbench;
  import swrl_pkg::*;
  localparam logic [63:0] ID = 64'h5A3C_0F96_C3A5_7E10; // Arbitrary value
  logic       clk;
  logic       rst;
  logic       mem_ready;
  logic       pres;
  wire        pull;
  wire        line;
  wire        dq_oe;
  wire        dq_out;
  wire        rst_seen;
  int         resets_seen = 0;
  wire        od_flag;
  wire        rc_flag;
  wire        selected;
  wire        mem_valid;
  wire  [7:0] mem_data;
  int         err_count;
  int         samples_checked;

  // Pull-up line: low when either side pulls
  assign line = ~(pull | dq_oe);

  // Reset lengths sit above every slot low: std zero 3758, od zero 508 cycles
  swrl_rom_layer #(.ROM_ID(ID), .RST_LONG_CYC(3900), .OD_KEEP_CYC(800), .OD_RST_CYC(600),
    .STD_PDH_CYC(50), .STD_PDL_CYC(100)) u_swrl_rom_layer (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_dq(line), .o_dq_out(dq_out), .o_dq_oe(dq_oe),
    .o_overdrive_flag(od_flag), .o_resume_flag(rc_flag), .o_selected(selected),
    .o_reset_seen(rst_seen), .o_mem_data(mem_data), .o_mem_valid(mem_valid),
    .i_mem_ready(mem_ready));

  swrl_master_model u_swrl_master_model (
    .i_clk_sys(clk), .i_line(line), .o_pull(pull));

  // Count recognised bus resets from the one-cycle indication
  always @(posedge clk) begin
    if (rst_seen === 1'b1) begin
      resets_seen <= resets_seen + 1;
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Standard reset, then overdrive-skip sent at standard timing
  task automatic t_std_odskip();
    u_swrl_master_model.bus_reset(4000, 1'b0, pres);
    `CHK("presence", 1'b1, pres)
    `CHK("od_flag", 1'b0, od_flag)
    u_swrl_master_model.write_byte(CMD_OD_SKIP, 1'b0, 0);
    `CHK("od_flag", 1'b1, od_flag)
    `CHK("selected", 1'b1, selected)
    $display("test t_std_odskip done");
  endtask : t_std_odskip

  // Short overdrive reset keeps speed; resume refused with flag clear
  task automatic t_od_resume();
    u_swrl_master_model.bus_reset(700, 1'b1, pres);
    `CHK("presence", 1'b1, pres)
    `CHK("od_flag", 1'b1, od_flag)
    `CHK("selected", 1'b0, selected)
    u_swrl_master_model.write_byte(CMD_RESUME, 1'b1, 0);
    `CHK("selected", 1'b0, selected)
    `CHK("rc_flag", 1'b0, rc_flag)
    $display("test t_od_resume done");
  endtask : t_od_resume

  // Overdrive-match wrong on the first ID bit, stopped after two bits, keeps overdrive
  task automatic t_od_match_miss();
    u_swrl_master_model.bus_reset(700, 1'b1, pres);
    u_swrl_master_model.write_byte(CMD_OD_MATCH, 1'b1, 0);
    u_swrl_master_model.write_bit(~ID[0], 1'b1);
    u_swrl_master_model.write_bit(ID[1], 1'b1);
    `CHK("selected", 1'b0, selected)
    `CHK("od_flag", 1'b1, od_flag)
    `CHK("rc_flag", 1'b0, rc_flag)
    $display("test t_od_match_miss done");
  endtask : t_od_match_miss

  // Bounded wait for a byte, compare, then pop it
  task automatic pop_check(input logic [7:0] exp);
    int n;
    n = 0;
    while (mem_valid !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    if (n == 8) begin
      err_count++;
      print_verdict();
    end else begin
      `CHK("mem_data", exp, mem_data)
      mem_ready = 1'b1;
      @(negedge clk);
      mem_ready = 1'b0;
      @(negedge clk);
    end
  endtask : pop_check

  // Skip, then three bytes while the consumer stalls; none may be lost
  task automatic t_skip_stall();
    u_swrl_master_model.bus_reset(700, 1'b1, pres);
    u_swrl_master_model.write_byte(CMD_SKIP, 1'b1, 0);
    `CHK("selected", 1'b1, selected)
    u_swrl_master_model.write_byte(8'hA1, 1'b1, 200);
    u_swrl_master_model.write_byte(8'h5E, 1'b1, 0);
    u_swrl_master_model.write_byte(8'hC3, 1'b1, 0);
    pop_check(8'hA1);
    pop_check(8'h5E);
    pop_check(8'hC3);
    `CHK("mem_valid", 1'b0, mem_valid)
    $display("test t_skip_stall done");
  endtask : t_skip_stall

  // Long reset drops overdrive; presence then at standard timing
  task automatic t_long_reset();
    u_swrl_master_model.bus_reset(4000, 1'b0, pres);
    `CHK("presence", 1'b1, pres)
    `CHK("od_flag", 1'b0, od_flag)
    `CHK("selected", 1'b0, selected)
    $display("test t_long_reset done");
  endtask : t_long_reset

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Main sequence; inputs move on falling edges only
  initial begin
    rst = 1'b1;
    mem_ready = 1'b0;
    err_count = 0;
    samples_checked = 0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    `CHK("od_flag", 1'b0, od_flag)
    `CHK("dq_oe", 1'b0, dq_oe)
    t_std_odskip();
    t_od_resume();
    t_od_match_miss();
    t_skip_stall();
    t_long_reset();
    `CHK("reset_count", 5, resets_seen)
    `CHK("dq_out", 1'b0, dq_out)
    print_verdict();
  end
endmodule : testbench
